// file: include/tia_pkg.sv
/*
  constants and types for the trace identification system-register bank.
  assumes a system-register access port driven by the processor pipeline.
*/
package tia_pkg;

  // ==========================================================
  // access encoding
  localparam logic [1:0] TIA_OP0 = 2'h2;
  localparam logic [2:0] TIA_OP1 = 3'h1;
  localparam logic [3:0] TIA_CRN_ID = 4'h0;
  localparam logic [3:0] TIA_CRN_CID = 4'h3;
  localparam logic [3:0] TIA_CRM_ID0 = 4'h8;
  localparam logic [3:0] TIA_CRM_ID1 = 4'h9;
  localparam logic [3:0] TIA_CRM_CID = 4'h0;
  localparam logic [2:0] TIA_OP2_ID = 3'h7;
  localparam logic [2:0] TIA_OP2_CID0 = 3'h0;

  // ==========================================================
  // exception levels and trap answer
  localparam logic [1:0] TIA_EL0 = 2'h0;
  localparam logic [1:0] TIA_EL1 = 2'h1;
  localparam logic [1:0] TIA_EL2 = 2'h2;
  localparam logic [1:0] TIA_EL3 = 2'h3;
  localparam logic [5:0] TIA_EC_SYSREG = 6'h18;

  // ==========================================================
  // capability register one fields, comparator width limit and reset value
  localparam int TIA_DESIGNER_LSB = 24;
  localparam int TIA_RES1_LSB = 12;
  localparam int TIA_MAJ_LSB = 8;
  localparam int TIA_MIN_LSB = 4;
  localparam logic [3:0] TIA_RES1_VAL = 4'hf;
  localparam logic [3:0] TIA_ARCH_ALL_ONES = 4'hf;
  localparam int TIA_CID_MAX = 64;
  localparam logic [63:0] TIA_CID_RESET = 64'h0;

  typedef enum logic [1:0] {
    TIA_RSP_DATA,
    TIA_RSP_UNDEF,
    TIA_RSP_TRAP
  } tia_rsp_t;

endpackage : tia_pkg

// file: core/tia_cid_store.sv
/*
  holds the context-id comparator value with masked width.
  assumes one write port and one registered read port.
*/
`timescale 1ns/100ps
module tia_cid_store
  import tia_pkg::*;
#(
  parameter int CID_WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [63:0] wr_data,
  output logic [63:0] rd_data
);

  typedef struct packed {
    logic [63:0] value;
  } tia_cid_state_t;

  tia_cid_state_t state;
  tia_cid_state_t next_state;

  // ==========================================================
  // width mask
  function automatic logic [63:0] cid_mask(input int w);
    cid_mask = (w >= TIA_CID_MAX) ? '1 : ((64'h1 << w) - 64'h1);
  endfunction : cid_mask

  always_comb begin
    next_state = state;
    if (!rst_b) begin
      next_state.value = TIA_CID_RESET;
    end else if (wr_en) begin
      next_state.value = wr_data & cid_mask(CID_WIDTH);
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  assign rd_data = state.value;

endmodule : tia_cid_store

// file: core/tia_trace_id_regs.sv
/*
  trace identification register bank behind system-register moves.
  assumes one access per request pulse; trap bits are live levels.
*/
`timescale 1ns/100ps
module tia_trace_id_regs
  import tia_pkg::*;
#(
  parameter logic [7:0] DESIGNER_CODE = 8'h5a, // arbitrary value
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [63:0] CAP_ZERO_VALUE = 64'h0,
  parameter int CID_WIDTH = 32
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [1:0] OP0,
  input wire logic [2:0] OP1,
  input wire logic [3:0] CRN,
  input wire logic [3:0] CRM,
  input wire logic [2:0] OP2,
  input wire logic [63:0] WDATA,
  input wire logic [1:0] CURRENT_EXCEPTION_LEVEL,
  input wire logic LEVEL1_TRACE_TRAP_BIT,
  input wire logic LEVEL2_TRACE_TRAP_BIT,
  input wire logic LEVEL3_TRACE_TRAP_BIT,
  input wire logic LEVEL2_ENABLED,
  input wire logic FINE_GRAINED_TRAP_ENABLE,
  input wire logic TRACE_ID_READ_TRAP_BIT,
  output logic ACK,
  output logic [63:0] RDATA,
  output logic UNDEFINED,
  output logic TRAP,
  output logic [1:0] TRAP_LEVEL,
  output logic [5:0] TRAP_CLASS
);

  typedef struct packed {
    logic ack;
    logic [63:0] rdata;
    logic undef;
    logic trap;
    logic [1:0] trap_level;
    logic [5:0] trap_class;
  } tia_state_t;

  tia_state_t state;
  tia_state_t next_state;
  logic [63:0] cid_value;
  logic cid_wr;

  // ==========================================================
  // fixed capability value
  function automatic logic [63:0] cap_one();
    logic [63:0] v;
    v = 64'h0;
    v[TIA_DESIGNER_LSB +: 8] = DESIGNER_CODE;
    v[TIA_RES1_LSB +: 4] = TIA_RES1_VAL;
    v[TIA_MAJ_LSB +: 4] = TIA_ARCH_ALL_ONES;
    v[TIA_MIN_LSB +: 4] = TIA_ARCH_ALL_ONES;
    v[3:0] = REVISION;
    return v;
  endfunction : cap_one

  // ==========================================================
  // decode
  logic hit_id0;
  logic hit_id1;
  logic hit_cid;
  logic base_hit;
  assign base_hit = (OP0 == TIA_OP0) && (OP1 == TIA_OP1);
  assign hit_id0 = base_hit && CRN == TIA_CRN_ID && CRM == TIA_CRM_ID0
    && OP2 == TIA_OP2_ID && !WRITE;
  assign hit_id1 = base_hit && CRN == TIA_CRN_ID && CRM == TIA_CRM_ID1
    && OP2 == TIA_OP2_ID && !WRITE;
  assign hit_cid = base_hit && CRN == TIA_CRN_CID && CRM == TIA_CRM_CID
    && OP2 == TIA_OP2_CID0;

  // ==========================================================
  // access checks
  tia_rsp_t rsp;
  logic [1:0] lvl;
  always_comb begin
    rsp = TIA_RSP_DATA;
    lvl = TIA_EL1;
    unique case (CURRENT_EXCEPTION_LEVEL)
      TIA_EL0: begin
        rsp = TIA_RSP_UNDEF;
      end
      TIA_EL1: begin
        if (LEVEL1_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL1;
        end else if (LEVEL2_ENABLED && LEVEL2_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL2;
        end else if (LEVEL2_ENABLED && FINE_GRAINED_TRAP_ENABLE
            && TRACE_ID_READ_TRAP_BIT && !WRITE && !hit_cid) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL2;
        end else if (LEVEL3_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL3;
        end
      end
      TIA_EL2: begin
        if (LEVEL2_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL2;
        end else if (LEVEL3_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL3;
        end
      end
      TIA_EL3: begin
        if (LEVEL3_TRACE_TRAP_BIT) begin
          rsp = TIA_RSP_TRAP;
          lvl = TIA_EL3;
        end
      end
    endcase
  end

  logic mapped;
  assign mapped = hit_id0 || hit_id1 || hit_cid;
  // only the comparator has a write path
  assign cid_wr = REQ && RST_B && hit_cid && WRITE
    && rsp == TIA_RSP_DATA;

  // ==========================================================
  // answer register
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.undef = 1'b0;
    next_state.trap = 1'b0;
    if (!RST_B) begin
      next_state = '0;
    end else if (REQ) begin
      next_state.ack = 1'b1;
      next_state.rdata = 64'h0;
      next_state.trap_level = TIA_EL0;
      next_state.trap_class = 6'h0;
      if (!mapped) begin
        next_state.undef = 1'b1;
      end else if (rsp == TIA_RSP_UNDEF) begin
        next_state.undef = 1'b1;
      end else if (rsp == TIA_RSP_TRAP) begin
        next_state.trap = 1'b1;
        next_state.trap_level = lvl;
        next_state.trap_class = TIA_EC_SYSREG;
      end else if (!WRITE) begin
        if (hit_id0) begin
          next_state.rdata = CAP_ZERO_VALUE;
        end else if (hit_id1) begin
          next_state.rdata = cap_one();
        end else begin
          next_state.rdata = cid_value;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    state <= next_state;
  end

  tia_cid_store #(
    .CID_WIDTH(CID_WIDTH)
  ) u_cid (
    .clock(CLOCK),
    .rst_b(RST_B),
    .wr_en(cid_wr),
    .wr_data(WDATA),
    .rd_data(cid_value)
  );

  assign ACK = state.ack;
  assign RDATA = state.rdata;
  assign UNDEFINED = state.undef;
  assign TRAP = state.trap;
  assign TRAP_LEVEL = state.trap_level;
  assign TRAP_CLASS = state.trap_class;

endmodule : tia_trace_id_regs

// file: verification/tia_trace_id_regs_props.sv
/* checker for the trace id register bank.
   assumes the bank defaults: designer code 8'h5a, revision 0. */
`timescale 1ns/100ps
module tia_trace_id_regs_chk
  import tia_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [1:0] OP0,
  input wire logic [2:0] OP1,
  input wire logic [3:0] CRN,
  input wire logic [3:0] CRM,
  input wire logic [2:0] OP2,
  input wire logic [1:0] CURRENT_EXCEPTION_LEVEL,
  input wire logic LEVEL3_TRACE_TRAP_BIT,
  input wire logic ACK,
  input wire logic [63:0] RDATA,
  input wire logic UNDEFINED,
  input wire logic TRAP,
  input wire logic [1:0] TRAP_LEVEL,
  input wire logic [5:0] TRAP_CLASS
);
  // ==========================================================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  wire logic rd3 = REQ && !WRITE && CURRENT_EXCEPTION_LEVEL == 2'h3 &&
    OP0 == 2'h2 && OP1 == 3'h1 && CRN == 4'h0 && CRM == 4'h9 && OP2 == 3'h7;
  AST_ACK_FOLLOWS: assert property (REQ |=> ACK)
    else $error("no answer one cycle after a request");
  AST_NO_SPURIOUS: assert property (
    !REQ |=> !ACK && !TRAP && !UNDEFINED)
    else $error("answer without a request");
  AST_LOW_LEVEL: assert property (
    REQ && CURRENT_EXCEPTION_LEVEL == 2'h0 |=> UNDEFINED && !TRAP)
    else $error("lowest level access not undefined");
  AST_CLASS: assert property (TRAP |-> ACK && TRAP_CLASS == 6'h18)
    else $error("trap class wrong");
  AST_TOP_TRAP: assert property (
    rd3 && LEVEL3_TRACE_TRAP_BIT |=> TRAP && TRAP_LEVEL == 2'h3)
    else $error("level 3 trap missing");
  AST_TOP_DATA: assert property (rd3 && !LEVEL3_TRACE_TRAP_BIT |=>
    ACK && !TRAP && RDATA[15:4] == 12'hfff && RDATA[63:32] == 32'h0)
    else $error("capability one fields wrong");
  AST_EXCLUSIVE: assert property (ACK |-> !(TRAP && UNDEFINED))
    else $error("trap and undefined together");
  AST_HOLD: assert property (
    !REQ |=> $stable(RDATA) && $stable(TRAP_LEVEL))
    else $error("answer changed without a request");
  cover property (ACK && TRAP);
  cover property (ACK && UNDEFINED);
  cover property (ACK && !TRAP && !UNDEFINED);
endmodule : tia_trace_id_regs_chk

bind tia_trace_id_regs tia_trace_id_regs_chk tia_trace_id_regs_chk_i (
  .CLOCK, .RST_B, .REQ, .WRITE, .OP0, .OP1, .CRN, .CRM, .OP2,
  .CURRENT_EXCEPTION_LEVEL, .LEVEL3_TRACE_TRAP_BIT, .ACK, .RDATA,
  .UNDEFINED, .TRAP, .TRAP_LEVEL, .TRAP_CLASS);

// file: verification/tia_trace_id_regs_tb.sv
/* self-checking bench for the trace id register bank.
   assumes one answer per request, one cycle later. */
`timescale 1ns/100ps
module tia_trace_id_regs_tb
  import tia_pkg::*;
;
  localparam logic [63:0] ID1 = 64'h5a00fff0;
  logic clock, rst_b = 0, req = 0, wr = 0, undef, trap, ack;
  logic [3:0] crn = 0, crm = 0;
  logic [2:0] op2 = 0;
  logic [1:0] el = 0, tlvl;
  logic [1:0] op0 = 2'h2;
  logic [2:0] op1 = 3'h1;
  logic [5:0] t = 0, tcls;
  logic [63:0] wd = 0, wdata = 0, rdata;
  logic [73:0] q[$];
  logic [73:0] e;
  int n_errors = 0, tests_run = 0, i;
  // ==========================================================
  // design
  tia_trace_id_regs #(.DESIGNER_CODE(8'h5a), .CID_WIDTH(32))
    tia_trace_id_regs_i (.CLOCK(clock), .RST_B(rst_b), .REQ(req),
    .WRITE(wr), .OP0(op0), .OP1(op1), .CRN(crn), .CRM(crm), .OP2(op2),
    .WDATA(wdata), .CURRENT_EXCEPTION_LEVEL(el),
    .LEVEL1_TRACE_TRAP_BIT(t[0]), .LEVEL2_TRACE_TRAP_BIT(t[1]),
    .LEVEL3_TRACE_TRAP_BIT(t[2]), .LEVEL2_ENABLED(t[3]),
    .FINE_GRAINED_TRAP_ENABLE(t[4]), .TRACE_ID_READ_TRAP_BIT(t[5]),
    .ACK(ack), .RDATA(rdata), .UNDEFINED(undef), .TRAP(trap),
    .TRAP_LEVEL(tlvl), .TRAP_CLASS(tcls));
  // ==========================================================
  // expected answer: {undefined, trap, level}, then class and data
  function automatic logic [3:0] rsp(input logic [1:0] l,
    input logic [5:0] b, input logic id, input logic bad);
    if (bad || l == 2'h0) return 4'h8;
    if (l == 2'h1 && b[0]) return 4'h5;
    if (l == 2'h1 && b[3] && b[1]) return 4'h6;
    if (l == 2'h1 && id && b[3] && b[4] && b[5]) return 4'h6;
    if (l == 2'h2 && b[1]) return 4'h6;
    if (b[2]) return 4'h7;
    return 4'h0;
  endfunction : rsp
  task automatic acc(input logic w, input logic [3:0] n, m,
    input logic [2:0] o, input logic [1:0] l, input logic [5:0] b,
    input logic [63:0] ed, input logic bad);
    logic [3:0] c;
    c = rsp(l, b, n == 4'h0, bad);
    q.push_back({c, (c[2] ? TIA_EC_SYSREG : 6'h0),
      ((c == 4'h0 && !w) ? ed : 64'h0)});
    req = 1;
    wr = w;
    crn = n;
    crm = m;
    op2 = o;
    el = l;
    t = b;
    wdata = wd;
    @(posedge clock);
    #1;
  endtask : acc
  task automatic tend(input string s);
    req = 0;
    repeat (3) @(posedge clock);
    #1;
    if (q.size() != 0) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, q.size(), 0);
      q = {};
    end
    $display("test %s done", s);
  endtask : tend
  task automatic final_report;
    $display("compares %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // ==========================================================
  // checking
  always @(negedge clock) begin
    if (ack === 1'b1) begin
      tests_run++;
      if (q.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t got %h exp %h", $time, ack, 1'b0);
      end else begin
        e = q.pop_front();
        if ({undef, trap, tlvl, tcls, rdata} !== e) begin
          n_errors++;
          $display("MISMATCH t=%0t got %h exp %h", $time,
            {undef, trap, tlvl, tcls, rdata}, e);
        end
      end
    end
  end
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  initial begin
    #(2000 * 50);
    n_errors++;
    final_report;
  end
  // ==========================================================
  // tests
  initial begin
    wd = {32'h0, $urandom(32'ha6eb227c)};
    repeat (6) @(posedge clock);
    #1;
    rst_b = 1;
    acc(0, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, 64'h0, 0);
    wd = {$urandom, $urandom};
    acc(1, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, 64'h0, 0);
    acc(0, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, {32'h0, wd[31:0]}, 0);
    wd = ~wd;
    acc(1, 4'h3, 4'h0, 3'h0, 2'h1, 6'h01, 64'h0, 0);
    acc(0, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, {32'h0, ~wd[31:0]}, 0);
    tend("comparator");
    for (i = 0; i < 256; i++) begin
      wd = {$urandom, $urandom};
      acc(0, 4'h0, {3'h4, i[0]}, 3'h7, i[7:6], i[5:0],
        i[0] ? ID1 : 64'h0, 0);
    end
    tend("levels");
    acc(1, 4'h0, 4'h9, 3'h7, 2'h3, 6'h0, 64'h0, 1);
    acc(0, 4'h5, 4'h0, 3'h0, 2'h3, 6'h0, 64'h0, 1);
    op0 = 2'h3;
    acc(0, 4'h0, 4'h9, 3'h7, 2'h3, 6'h0, 64'h0, 1);
    op0 = 2'h2;
    op1 = 3'h0;
    acc(1, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, 64'h0, 1);
    op1 = 3'h1;
    acc(0, 4'h0, 4'h9, 3'h7, 2'h3, 6'h0, ID1, 0);
    tend("refused");
    rst_b = 0;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1;
    acc(0, 4'h3, 4'h0, 3'h0, 2'h3, 6'h0, 64'h0, 0);
    tend("reset");
    final_report;
  end
endmodule : tia_trace_id_regs_tb
